// >>> crp_pkg.sv
/*
  package for the clock, range and power configuration register slice:
  byte addresses, field positions, reset values and the register carrier types.
  assumes a byte-wide configuration port with 15-bit addresses.
*/
package crp_pkg;

  localparam int          ADDR_W              = 15;
  localparam logic [14:0] ADDR_SYNC_DELAY     = 15'h0029;
  localparam logic [14:0] ADDR_CLK_IN_A       = 15'h002A;
  localparam logic [14:0] ADDR_CLK_SUP_B      = 15'h002B;
  localparam logic [14:0] ADDR_EDGE_POS_0     = 15'h002C;
  localparam logic [14:0] ADDR_EDGE_POS_2     = 15'h002E;
  localparam logic [14:0] ADDR_FULL_SCALE_0   = 15'h0030;
  localparam logic [14:0] ADDR_FULL_SCALE_1   = 15'h0031;
  localparam logic [14:0] ADDR_POWER_FIRST    = 15'h0037;

  localparam logic [7:0]  RST_SYNC_DELAY      = 8'h80;
  localparam logic [7:0]  RST_CLK_IN_A        = 8'h00;
  localparam logic [7:0]  RST_CLK_SUP_B       = 8'h10;
  localparam logic [23:0] RST_EDGE_POS        = 24'h000000;
  localparam logic [15:0] RST_FULL_SCALE      = 16'hA000;
  localparam logic [7:0]  RST_POWER_FIRST     = 8'h4B;

  localparam int          BIT_SYNC_INVERT     = 0;
  localparam int          BIT_SYNC_PECL       = 1;
  localparam int          BIT_DEVICE_SAMPLE_CLOCK_PECL     = 2;
  localparam int          BIT_CLOCK_QUIET     = 0;
  localparam int          BIT_ANALOG_QUIET    = 2;
  localparam int          SYNC_SEL_MSB        = 3;

  localparam logic [7:0]  POWER_CODE_LOW      = 8'h46;
  localparam logic [7:0]  POWER_CODE_HIGH     = 8'h4B;
  localparam logic [15:0] FULL_SCALE_MIN_REC  = 16'h2000;

  typedef enum logic [1:0] {
    CRP_MODE_HIGH_PERF = 2'b01,
    CRP_MODE_LOW_POWER = 2'b10
  } crp_power_mode_t;

  // config port request carrier
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [14:0]       addr;
    logic [7:0]        wdata;
  } crp_req_t;

  // analog-facing controls
  typedef struct packed {
    logic              device_clock_pecl_enable;
    logic              sync_input_pecl_enable;
    logic              sync_input_invert;
    logic              analog_rail_quieting_enable;
    logic              clock_rail_quieting_enable;
    logic [3:0]        sync_delay_select;
    logic [15:0]       full_scale_setting;
    logic [7:0]        power_mode_code;
  } crp_ctrl_t;

endpackage

// >>> crp_edge_capture.sv
/*
  sync edge position capture: holds the last 24-bit position sample and
  applies the selectable sync polarity before alignment.
  assumes position samples arrive synchronous to the core clock.
*/
`timescale 1ns/100ps
module crp_edge_capture (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_invert,
  input  wire logic        i_sync_raw,
  input  wire logic        i_pos_valid,
  input  wire logic [23:0] i_pos_sample,
  output logic             o_sync_aligned,
  output logic [23:0]      o_position
);
  import crp_pkg::*;

  logic        sync_q;
  logic        next_sync_q;
  logic [23:0] next_position;

  always_comb begin
    next_sync_q   = i_sync_raw ^ i_invert;
    next_position = i_pos_valid ? i_pos_sample : o_position;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync_q     <= 1'b0;
      o_position <= RST_EDGE_POS;
    end else begin
      sync_q     <= next_sync_q;
      o_position <= next_position;
    end
  end

  assign o_sync_aligned = sync_q;

  property p_pos_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      !i_pos_valid |=> o_position == $past(o_position);
  endproperty
  a_pos_hold: assert property (p_pos_hold) else $error("position changed without capture");

  property p_invert;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      1'b1 |=> o_sync_aligned == ($past(i_sync_raw) ^ $past(i_invert));
  endproperty
  a_invert: assert property (p_invert) else $error("sync polarity wrong");

endmodule

// >>> crp_config_regs.sv
/*
  clock input, supply quieting, sync edge position, full-scale and first
  power mode configuration registers, reached over the byte-wide serial
  configuration port (write strobe, read strobe, address, data).
  assumes the port decoder presents one-cycle strobes synchronous to i_core_clk.
*/
//
// Overview of operation
// - invert bit flips sync before alignment
// - device_sample_clock pecl bit switches clock input
// - sync pecl bit switches sync input
// - analog rail quieting enable bit
// - clock rail quieting enable bit
// - read-only 24-bit sync edge position
// - 16-bit full scale, reset 0xA000
// - power code 0x46 low, 0x4B high
// - low four bits select sync delay
`timescale 1ns/100ps
module crp_config_regs (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire crp_pkg::crp_req_t i_req,
  input  wire logic              i_sync_raw,
  input  wire logic              i_pos_valid,
  input  wire logic [23:0]       i_pos_sample,
  output logic [7:0]             o_rdata,
  output logic                   o_rvalid,
  output crp_pkg::crp_ctrl_t     o_ctrl,
  output logic                   o_sync_aligned,
  output crp_pkg::crp_power_mode_t o_power_mode,
  output logic                   o_full_scale_low
);
  import crp_pkg::*;

  logic [7:0]  sync_delay;
  logic [7:0]  clk_in_a;
  logic [7:0]  clk_sup_b;
  logic [15:0] full_scale;
  logic [7:0]  power_first;
  logic [7:0]  next_sync_delay;
  logic [7:0]  next_clk_in_a;
  logic [7:0]  next_clk_sup_b;
  logic [15:0] next_full_scale;
  logic [7:0]  next_power_first;
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic [23:0] position;
  crp_power_mode_t next_power_mode;

  function automatic logic hit(input logic [14:0] a, input logic [14:0] b);
    hit = (a == b);
  endfunction

  crp_edge_capture u_edge (
    .i_core_clk     (i_core_clk),
    .i_rst_n        (i_rst_n),
    .i_invert       (clk_in_a[BIT_SYNC_INVERT]),
    .i_sync_raw     (i_sync_raw),
    .i_pos_valid    (i_pos_valid),
    .i_pos_sample   (i_pos_sample),
    .o_sync_aligned (o_sync_aligned),
    .o_position     (position)
  );

  // register writes; reserved bits are stored as written, software keeps them default
  always_comb begin
    next_sync_delay  = sync_delay;
    next_clk_in_a    = clk_in_a;
    next_clk_sup_b   = clk_sup_b;
    next_full_scale  = full_scale;
    next_power_first = power_first;
    if (i_req.wr) begin
      if (hit(i_req.addr, ADDR_SYNC_DELAY)) begin
        next_sync_delay = i_req.wdata;
      end
      if (hit(i_req.addr, ADDR_CLK_IN_A)) begin
        next_clk_in_a = i_req.wdata;
      end
      if (hit(i_req.addr, ADDR_CLK_SUP_B)) begin
        next_clk_sup_b = i_req.wdata;
      end
      if (hit(i_req.addr, ADDR_FULL_SCALE_0)) begin
        next_full_scale[7:0] = i_req.wdata;
      end
      if (hit(i_req.addr, ADDR_FULL_SCALE_1)) begin
        next_full_scale[15:8] = i_req.wdata;
      end
      if (hit(i_req.addr, ADDR_POWER_FIRST)) begin
        next_power_first = i_req.wdata;
      end
    end
  end

  // reads return a byte the cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = i_req.rd;
    if (i_req.rd) begin
      unique case (1'b1)
        hit(i_req.addr, ADDR_SYNC_DELAY):   next_rdata = sync_delay;
        hit(i_req.addr, ADDR_CLK_IN_A):     next_rdata = clk_in_a;
        hit(i_req.addr, ADDR_CLK_SUP_B):    next_rdata = clk_sup_b;
        hit(i_req.addr, ADDR_EDGE_POS_0):   next_rdata = position[7:0];
        hit(i_req.addr, ADDR_EDGE_POS_0 + 15'h0001): next_rdata = position[15:8];
        hit(i_req.addr, ADDR_EDGE_POS_2):   next_rdata = position[23:16];
        hit(i_req.addr, ADDR_FULL_SCALE_0): next_rdata = full_scale[7:0];
        hit(i_req.addr, ADDR_FULL_SCALE_1): next_rdata = full_scale[15:8];
        hit(i_req.addr, ADDR_POWER_FIRST):  next_rdata = power_first;
        default:                            next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    if (power_first == POWER_CODE_LOW) begin
      next_power_mode = CRP_MODE_LOW_POWER;
    end else begin
      next_power_mode = CRP_MODE_HIGH_PERF;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      sync_delay   <= RST_SYNC_DELAY;
      clk_in_a     <= RST_CLK_IN_A;
      clk_sup_b    <= RST_CLK_SUP_B;
      full_scale   <= RST_FULL_SCALE;
      power_first  <= RST_POWER_FIRST;
      o_rdata      <= 8'h00;
      o_rvalid     <= 1'b0;
      o_power_mode <= CRP_MODE_HIGH_PERF;
    end else begin
      sync_delay   <= next_sync_delay;
      clk_in_a     <= next_clk_in_a;
      clk_sup_b    <= next_clk_sup_b;
      full_scale   <= next_full_scale;
      power_first  <= next_power_first;
      o_rdata      <= next_rdata;
      o_rvalid     <= next_rvalid;
      o_power_mode <= next_power_mode;
    end
  end

  always_comb begin
    o_ctrl.device_clock_pecl_enable    = clk_in_a[BIT_DEVICE_SAMPLE_CLOCK_PECL];
    o_ctrl.sync_input_pecl_enable      = clk_in_a[BIT_SYNC_PECL];
    o_ctrl.sync_input_invert           = clk_in_a[BIT_SYNC_INVERT];
    o_ctrl.analog_rail_quieting_enable = clk_sup_b[BIT_ANALOG_QUIET];
    o_ctrl.clock_rail_quieting_enable  = clk_sup_b[BIT_CLOCK_QUIET];
    o_ctrl.sync_delay_select           = sync_delay[SYNC_SEL_MSB:0];
    o_ctrl.full_scale_setting          = full_scale;
    o_ctrl.power_mode_code             = power_first;
  end

  // flag only; low codes are accepted, just degraded
  assign o_full_scale_low = full_scale < FULL_SCALE_MIN_REC;

  sequence s_wr_clk_a;
    i_req.wr && i_req.addr == ADDR_CLK_IN_A;
  endsequence

  property p_pecl_follows;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_wr_clk_a |=> o_ctrl.device_clock_pecl_enable == $past(i_req.wdata[2]);
  endproperty
  a_pecl_follows: assert property (p_pecl_follows) else $error("device_sample_clock pecl not updated");

  property p_sync_pecl;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      s_wr_clk_a |=> o_ctrl.sync_input_pecl_enable == $past(i_req.wdata[1]);
  endproperty
  a_sync_pecl: assert property (p_sync_pecl) else $error("sync pecl not updated");

  property p_quiet_analog;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr == ADDR_CLK_SUP_B
      |=> o_ctrl.analog_rail_quieting_enable == $past(i_req.wdata[2]);
  endproperty
  a_quiet_analog: assert property (p_quiet_analog) else $error("analog quieting wrong");

  property p_quiet_clock;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr == ADDR_CLK_SUP_B
      |=> o_ctrl.clock_rail_quieting_enable == $past(i_req.wdata[0]);
  endproperty
  a_quiet_clock: assert property (p_quiet_clock) else $error("clock quieting wrong");

  property p_reset_defaults;
    @(posedge i_core_clk)
      !i_rst_n |=> o_ctrl.full_scale_setting == 16'hA000 && o_ctrl.power_mode_code == 8'h4B;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset value wrong");

  property p_fs_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr == ADDR_FULL_SCALE_1
      |=> o_ctrl.full_scale_setting[15:8] == $past(i_req.wdata);
  endproperty
  a_fs_write: assert property (p_fs_write) else $error("full scale high byte lost");

  property p_low_power;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr == ADDR_POWER_FIRST && i_req.wdata == 8'h46
      |=> ##1 o_power_mode == CRP_MODE_LOW_POWER;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power mode not entered");

  property p_delay_sel;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.wr && i_req.addr == ADDR_SYNC_DELAY
      |=> o_ctrl.sync_delay_select == $past(i_req.wdata[3:0]);
  endproperty
  a_delay_sel: assert property (p_delay_sel) else $error("delay select wrong");

  property p_read_lat;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_req.rd && i_req.addr == ADDR_POWER_FIRST && !i_req.wr
      |=> o_rvalid && o_rdata == $past(power_first);
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read data wrong");

endmodule

// >>> tb_clock_range_power_config_regs.sv
/*
  self-checking bench for the clock, range and power configuration slice.
  assumes one-cycle strobes, 1-cycle write/read latency, 2-cycle power mode.
*/
`timescale 1ns/100ps
module tb_clock_range_power_config_regs;
  import crp_pkg::*;
  logic            i_core_clk;
  logic            i_rst_n;
  crp_req_t        i_req;
  logic            i_sync_raw;
  logic            i_pos_valid;
  logic [23:0]     i_pos_sample;
  logic [7:0]      o_rdata;
  logic            o_rvalid;
  crp_ctrl_t       o_ctrl;
  logic            o_sync_aligned;
  crp_power_mode_t o_power_mode;
  logic            o_full_scale_low;
  int              num_errors = 0;
  int              checks = 0;

  crp_config_regs DUT (
    .i_core_clk       (i_core_clk),
    .i_rst_n          (i_rst_n),
    .i_req            (i_req),
    .i_sync_raw       (i_sync_raw),
    .i_pos_valid      (i_pos_valid),
    .i_pos_sample     (i_pos_sample),
    .o_rdata          (o_rdata),
    .o_rvalid         (o_rvalid),
    .o_ctrl           (o_ctrl),
    .o_sync_aligned   (o_sync_aligned),
    .o_power_mode     (o_power_mode),
    .o_full_scale_low (o_full_scale_low)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("counts: checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
  endtask

  // strobe held one cycle, dropped at the edge that takes it
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_core_clk);
    i_req <= '0;
    #1;
  endtask

  task automatic rdc(input logic [14:0] a, input logic [7:0] e);
    @(posedge i_core_clk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_core_clk);
    i_req <= '0;
    #1;
    chk(24'(o_rvalid), 24'h1);
    chk(24'(o_rdata), 24'(e));
  endtask

  // aligned output lags the raw level by one cycle
  task automatic sync_chk(input logic raw, input logic e);
    @(posedge i_core_clk);
    i_sync_raw <= raw;
    @(posedge i_core_clk);
    #1;
    chk(24'(o_sync_aligned), 24'(e));
  endtask

  task automatic t_defaults();
    rdc(ADDR_SYNC_DELAY, RST_SYNC_DELAY);
    rdc(ADDR_CLK_IN_A, RST_CLK_IN_A);
    rdc(ADDR_CLK_SUP_B, RST_CLK_SUP_B);
    for (int i = 0; i < 3; i++) begin
      rdc(ADDR_EDGE_POS_0 + 15'(i), 8'h00);
    end
    rdc(ADDR_FULL_SCALE_0, 8'h00);
    rdc(ADDR_FULL_SCALE_1, 8'hA0);
    rdc(ADDR_POWER_FIRST, RST_POWER_FIRST);
    @(posedge i_core_clk);
    #1;
    chk(24'(o_rvalid), 24'h0);
    chk(24'(o_power_mode), 24'(CRP_MODE_HIGH_PERF));
    chk(24'(o_ctrl.full_scale_setting), 24'hA000);
    $display("done: defaults");
  endtask

  task automatic t_clock();
    wr(ADDR_CLK_IN_A, 8'h04);
    chk(24'({o_ctrl.device_clock_pecl_enable, o_ctrl.sync_input_pecl_enable,
             o_ctrl.sync_input_invert}), 24'h4);
    sync_chk(1'b1, 1'b1);
    wr(ADDR_CLK_IN_A, 8'h03);
    chk(24'({o_ctrl.device_clock_pecl_enable, o_ctrl.sync_input_pecl_enable,
             o_ctrl.sync_input_invert}), 24'h3);
    sync_chk(1'b1, 1'b0);
    sync_chk(1'b0, 1'b1);
    rdc(ADDR_CLK_IN_A, 8'h03);
    wr(ADDR_CLK_SUP_B, 8'h14);
    chk(24'({o_ctrl.analog_rail_quieting_enable, o_ctrl.clock_rail_quieting_enable}),
        24'h2);
    wr(ADDR_CLK_SUP_B, 8'h11);
    chk(24'({o_ctrl.analog_rail_quieting_enable, o_ctrl.clock_rail_quieting_enable}),
        24'h1);
    rdc(ADDR_CLK_SUP_B, 8'h11);
    $display("done: clock");
  endtask

  task automatic t_position();
    @(posedge i_core_clk);
    i_pos_valid  <= 1'b1;
    i_pos_sample <= 24'hABCDEF;
    @(posedge i_core_clk);
    i_pos_valid  <= 1'b0;
    i_pos_sample <= 24'h123456;
    rdc(ADDR_EDGE_POS_0, 8'hEF);
    rdc(ADDR_EDGE_POS_0 + 15'h1, 8'hCD);
    rdc(ADDR_EDGE_POS_2, 8'hAB);
    wr(ADDR_EDGE_POS_0, 8'h55);
    rdc(ADDR_EDGE_POS_0, 8'hEF);
    wr(ADDR_SYNC_DELAY, {RST_SYNC_DELAY[7:4], 4'hF});
    chk(24'(o_ctrl.sync_delay_select), 24'hF);
    $display("done: position");
  endtask

  task automatic t_range();
    wr(ADDR_SYNC_DELAY, 8'h85);
    chk(24'(o_ctrl.sync_delay_select), 24'h5);
    rdc(ADDR_SYNC_DELAY, 8'h85);
    wr(ADDR_FULL_SCALE_0, 8'hFF);
    wr(ADDR_FULL_SCALE_1, 8'h1F);
    chk(24'(o_ctrl.full_scale_setting), 24'h1FFF);
    chk(24'(o_full_scale_low), 24'h1);
    wr(ADDR_FULL_SCALE_0, 8'h00);
    wr(ADDR_FULL_SCALE_1, 8'h20);
    chk(24'(o_full_scale_low), 24'h0);
    rdc(ADDR_FULL_SCALE_1, 8'h20);
    $display("done: range");
  endtask

  task automatic t_power();
    logic [7:0]      codes [4];
    crp_power_mode_t modes [4];
    codes = '{8'h46, 8'h4B, 8'h47, 8'h46};
    modes = '{CRP_MODE_LOW_POWER, CRP_MODE_HIGH_PERF, CRP_MODE_HIGH_PERF,
              CRP_MODE_LOW_POWER};
    for (int i = 0; i < 4; i++) begin
      // calibration and link held off here
      // other power registers lie outside the slice
      wr(ADDR_POWER_FIRST, codes[i]);
      chk(24'(o_ctrl.power_mode_code), 24'(codes[i]));
      // calibration would follow this mode change
      @(posedge i_core_clk);
      #1;
      chk(24'(o_power_mode), 24'(modes[i]));
      rdc(ADDR_POWER_FIRST, codes[i]);
    end
    wr(15'h0040, 8'hFF);
    rdc(15'h7FFF, 8'h00);
    $display("done: power");
  endtask

  // second reset mid-run must restore the clk_in_a, full scale high byte, power code and position defaults
  task automatic t_rereset();
    do_reset();
    rdc(ADDR_CLK_IN_A, RST_CLK_IN_A);
    rdc(ADDR_FULL_SCALE_1, 8'hA0);
    rdc(ADDR_POWER_FIRST, RST_POWER_FIRST);
    rdc(ADDR_EDGE_POS_2, 8'h00);
    chk(24'(o_power_mode), 24'(CRP_MODE_HIGH_PERF));
    $display("done: rereset");
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    num_errors++;
    close_out();
  end

  initial begin
    i_rst_n      = 1'b0;
    i_req        = '0;
    i_sync_raw   = 1'b0;
    i_pos_valid  = 1'b0;
    i_pos_sample = 24'h000000;
    do_reset();
    t_defaults();
    t_clock();
    t_position();
    t_range();
    t_power();
    t_rereset();
    close_out();
  end
endmodule
